// ---- core/asr_pkg.sv ----
// shared constants and types for the static memory access controller
package asr_pkg;
    localparam int ASR_ADDR_W = 17;
    localparam int ASR_DATA_W = 8;
    localparam int ASR_CLK_PERIOD_NS = 20;
    // speed grade 1 selects the 70 ns figures, 0 the 55 ns figures
    localparam bit ASR_GRADE_SLOW = 1'b1;
    localparam int ASR_CYCLE_NS = ASR_GRADE_SLOW ? 70 : 55;
    localparam int ASR_ADDRESS_ACCESS_TIME_NS = ASR_GRADE_SLOW ? 70 : 55;
    localparam int ASR_GATE_ACCESS_TIME_NS = ASR_GRADE_SLOW ? 35 : 20;
    localparam int ASR_WRITE_DATA_SETUP_NS = ASR_GRADE_SLOW ? 30 : 25;
    localparam int ASR_ADDRESS_SETUP_TO_WRITE_END_NS = ASR_GRADE_SLOW ? 60 : 45;
    localparam int ASR_WRITE_PULSE_NS = ASR_GRADE_SLOW ? 50 : 45;
    localparam int ASR_FLOAT_NS = 25;
    localparam int ASR_WRITE_DATA_HOLD_NS = 0;
    localparam int ASR_SYNC_CYCLES = 2;
    // least times rounded up to whole cycles, never below one
    function automatic int asr_cycles_up(input int ns);
        int c;
        c = (ns + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : asr_cycles_up
    localparam int ASR_WR_PULSE_RAW = asr_cycles_up(ASR_ADDRESS_SETUP_TO_WRITE_END_NS);
    localparam int ASR_WR_PULSE_MIN = asr_cycles_up(ASR_WRITE_PULSE_NS);
    localparam int ASR_WR_CYC = (ASR_WR_PULSE_RAW > ASR_WR_PULSE_MIN) ?
        ASR_WR_PULSE_RAW : ASR_WR_PULSE_MIN;
    localparam int ASR_WR_SETUP_CYC = asr_cycles_up(ASR_WRITE_DATA_SETUP_NS);
    // read wait covers access time plus the two synchroniser stages
    localparam int ASR_RD_CYC = asr_cycles_up(ASR_ADDRESS_ACCESS_TIME_NS) + ASR_SYNC_CYCLES;
    localparam int ASR_TURN_CYC = asr_cycles_up(ASR_FLOAT_NS);
    localparam int ASR_CNT_W = 4;
    localparam logic [ASR_CNT_W-1:0] ASR_WR_CNT = ASR_CNT_W'(ASR_WR_CYC - 1);
    // counter value at which data goes out, a full setup time before the strobe rises
    localparam logic [ASR_CNT_W-1:0] ASR_WR_DATA_CNT = ASR_CNT_W'(ASR_WR_SETUP_CYC);
    localparam logic [ASR_CNT_W-1:0] ASR_RD_CNT = ASR_CNT_W'(ASR_RD_CYC - 1);
    localparam logic [ASR_CNT_W-1:0] ASR_TURN_CNT = ASR_CNT_W'(ASR_TURN_CYC - 1);
    localparam logic [ASR_CNT_W-1:0] ASR_CNT_ZERO = 4'h0;
    typedef enum {ASR_IDLE, ASR_RD_WAIT, ASR_WR_PULSE, ASR_RECOVER} asr_state_t;
endpackage : asr_pkg

// ---- core/asr_sync.sv ----
// two-stage synchroniser for the returned byte lines
`timescale 1ns/1ps
`default_nettype none
module asr_sync
    import asr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ASR_DATA_W-1:0] async_in,
    output logic [ASR_DATA_W-1:0] sync_out
);
    typedef struct packed {
        logic [ASR_DATA_W-1:0] stage1;
        logic [ASR_DATA_W-1:0] stage2;
    } asr_sync_t;
    asr_sync_t st;
    asr_sync_t next_st;
    always_comb
    begin
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign sync_out = st.stage2;
endmodule : asr_sync
`default_nettype wire

// ---- core/asr_ctrl.sv ----
// host-side controller driving an asynchronous 128k x 8 static memory
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl
    import asr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ASR_ADDR_W-1:0] req_address,
    input wire logic [ASR_DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [ASR_DATA_W-1:0] rsp_rdata,
    output logic [ASR_ADDR_W-1:0] word_address,
    output logic select_low_active_n,
    output logic select_high_active,
    output logic gate_n,
    output logic strobe_n,
    input wire logic [ASR_DATA_W-1:0] byte_lines_in,
    output logic [ASR_DATA_W-1:0] byte_lines_out,
    output logic byte_lines_oe
);
    typedef struct packed {
        asr_state_t state;
        logic [ASR_CNT_W-1:0] cnt;
        logic req_ready;
        logic rsp_valid;
        logic [ASR_DATA_W-1:0] rdata;
        logic [ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
        logic sel_n;
        logic sel;
        logic gate_n;
        logic strobe_n;
        logic oe;
    } asr_ctrl_t;

    asr_ctrl_t st;
    asr_ctrl_t next_st;
    // byte lines after the two-stage synchroniser
    logic [ASR_DATA_W-1:0] lines_sync;

    asr_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(byte_lines_in),
        .sync_out(lines_sync)
    );

    function automatic logic cnt_done(input logic [ASR_CNT_W-1:0] c);
        return c == ASR_CNT_ZERO;
    endfunction : cnt_done

    // counts down to zero and rests there
    function automatic logic [ASR_CNT_W-1:0] cnt_step(input logic [ASR_CNT_W-1:0] c);
        return cnt_done(c) ? ASR_CNT_ZERO : c - 1'b1;
    endfunction : cnt_step

    // address and both selects change on one edge, so no select runs ahead
    function automatic asr_ctrl_t open_access(input asr_ctrl_t s,
        input logic [ASR_ADDR_W-1:0] a);
        asr_ctrl_t o;
        o = s;
        o.req_ready = 1'b0;
        o.addr = a;
        o.sel_n = 1'b0;
        o.sel = 1'b1;
        return o;
    endfunction : open_access

    // standby with the memory outputs off; address and data left alone
    function automatic asr_ctrl_t park_pins(input asr_ctrl_t s);
        asr_ctrl_t p;
        p = s;
        p.sel_n = 1'b1;
        p.sel = 1'b0;
        p.gate_n = 1'b1;
        return p;
    endfunction : park_pins

    // reset image: selects inactive, gate and strobe high, nothing driven
    function automatic asr_ctrl_t idle_state();
        asr_ctrl_t s;
        s.state = ASR_IDLE;
        s.cnt = ASR_CNT_ZERO;
        s.req_ready = 1'b0;
        s.rsp_valid = 1'b0;
        s.rdata = '0;
        s.addr = '0;
        s.wdata = '0;
        s.sel_n = 1'b1;
        s.sel = 1'b0;
        s.gate_n = 1'b1;
        s.strobe_n = 1'b1;
        s.oe = 1'b0;
        return s;
    endfunction : idle_state

    // idle: pins parked, ready high; a request opens one access
    // read wait: gate and selects held until the byte has crossed the synchroniser
    // write pulse: strobe low throughout, data out a setup time before its end
    // recover: pins parked until the memory has floated its lines
    always_comb
    begin
        next_st = st;
        next_st.rsp_valid = 1'b0;
        next_st.cnt = cnt_step(st.cnt);
        case (st.state)
            ASR_IDLE:
            begin
                next_st.req_ready = 1'b1;
                if (req_valid && st.req_ready)
                begin
                    next_st = open_access(next_st, req_address);
                    if (req_write)
                    begin
                        // gate stays high so memory floats while written
                        next_st.gate_n = 1'b1;
                        next_st.strobe_n = 1'b0;
                        next_st.wdata = req_wdata;
                        next_st.oe = 1'b0;
                        next_st.cnt = ASR_WR_CNT;
                        next_st.state = ASR_WR_PULSE;
                    end
                    else
                    begin
                        next_st.strobe_n = 1'b1;
                        next_st.gate_n = 1'b0;
                        next_st.oe = 1'b0;
                        next_st.cnt = ASR_RD_CNT;
                        next_st.state = ASR_RD_WAIT;
                    end
                end
            end
            ASR_RD_WAIT:
            begin
                if (cnt_done(st.cnt))
                begin
                    // sample before the address or gate moves
                    next_st.rdata = lines_sync;
                    next_st.rsp_valid = 1'b1;
                    next_st = park_pins(next_st);
                    next_st.cnt = ASR_TURN_CNT;
                    next_st.state = ASR_RECOVER;
                end
            end
            ASR_WR_PULSE:
            begin
                if (st.cnt == ASR_WR_DATA_CNT)
                begin
                    next_st.oe = 1'b1;
                end
                if (cnt_done(st.cnt))
                begin
                    // strobe rise ends the write; address and data still held
                    next_st.strobe_n = 1'b1;
                    next_st.rsp_valid = 1'b1;
                    next_st.cnt = ASR_TURN_CNT;
                    next_st.state = ASR_RECOVER;
                end
            end
            ASR_RECOVER:
            begin
                next_st.oe = 1'b0;
                next_st = park_pins(next_st);
                if (cnt_done(st.cnt))
                begin
                    next_st.req_ready = 1'b1;
                    next_st.state = ASR_IDLE;
                end
            end
            default:
            begin
                next_st.state = ASR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st <= idle_state();
        end
        else
        begin
            st <= next_st;
        end
    end

    assign req_ready = st.req_ready;
    assign rsp_valid = st.rsp_valid;
    assign rsp_rdata = st.rdata;
    assign word_address = st.addr;
    assign select_low_active_n = st.sel_n;
    assign select_high_active = st.sel;
    assign gate_n = st.gate_n;
    assign strobe_n = st.strobe_n;
    assign byte_lines_out = st.wdata;
    assign byte_lines_oe = st.oe;
endmodule : asr_ctrl
`default_nettype wire

// ---- verification/asr_mem_model.sv ----
// behavioural static memory on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model
    import asr_pkg::*;
(
    input wire logic [ASR_ADDR_W-1:0] word_address,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic gate_n,
    input wire logic strobe_n,
    input wire logic [ASR_DATA_W-1:0] host_lines,
    input wire logic host_oe,
    output logic [ASR_DATA_W-1:0] byte_lines
);
    logic [ASR_DATA_W-1:0] mem [0:(1<<ASR_ADDR_W)-1];
    logic [ASR_DATA_W-1:0] acc, held, last;
    logic sel, rd, rd_late, wr;
    assign sel = !select_low_active_n && select_high_active;
    assign rd = sel && !gate_n && strobe_n;
    assign wr = sel && !strobe_n;
    assign #(ASR_ADDRESS_ACCESS_TIME_NS) acc = mem[word_address];
    assign #(ASR_GATE_ACCESS_TIME_NS) rd_late = rd;
    initial
    begin
        last = 8'h00;
        for (int i = 0; i < (1 << ASR_ADDR_W); i++)
            mem[i] = ASR_DATA_W'(i) ^ 8'hA5;
    end
    always @(*)
        if (wr)
            held = host_oe ? host_lines : ~last;
    always @(negedge wr)
        mem[word_address] = held;
    always @(*)
        if (rd && rd_late)
            last = acc;
    // released lines show the inverse of the last byte the memory drove on a read
    assign byte_lines = host_oe ? host_lines : (rd && rd_late) ? acc : ~last;
endmodule : asr_mem_model
`default_nettype wire

// ---- verification/asr_ctrl_properties.sv ----
// concurrent checks on the controller's memory pins
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_properties
    import asr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ASR_ADDR_W-1:0] word_address,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic gate_n,
    input wire logic strobe_n,
    input wire logic [ASR_DATA_W-1:0] byte_lines_out,
    input wire logic byte_lines_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rd_open;
        $fell(gate_n) && !select_low_active_n && select_high_active;
    endsequence
    sequence s_rd_hold;
        (!gate_n && strobe_n && $stable(word_address))[*4];
    endsequence
    a_read_window: assert property (s_rd_open |=> s_rd_hold)
        else $error("read window too short");
    a_read_select: assert property (!gate_n |-> strobe_n && !select_low_active_n)
        else $error("read without select or with strobe");
    a_write_overlap: assert property (!strobe_n |-> gate_n && select_high_active)
        else $error("write strobe outside selected gated state");
    a_host_drive: assert property (byte_lines_oe |-> gate_n && $past(gate_n))
        else $error("host drives while memory may drive");
    a_data_setup: assert property ($rose(strobe_n) |-> $past(byte_lines_oe, 2)
        && $past(byte_lines_oe) && $past(byte_lines_out, 2) == $past(byte_lines_out))
        else $error("write data setup too short");
    a_addr_to_end: assert property ($rose(strobe_n) |-> !$past(select_low_active_n, 3)
        && $past(word_address, 3) == $past(word_address))
        else $error("address setup to write end too short");
    a_addr_hold: assert property (!strobe_n |=> $stable(word_address))
        else $error("address moved during write");
    a_addr_early: assert property ($changed(word_address) |-> $past(strobe_n && gate_n))
        else $error("address moved inside an access");
    a_data_release: assert property ($rose(strobe_n) |=> !byte_lines_oe)
        else $error("write data not released");
endmodule : asr_ctrl_properties
bind asr_ctrl asr_ctrl_properties u_props (.ref_clk, .rst, .word_address,
    .select_low_active_n, .select_high_active, .gate_n, .strobe_n, .byte_lines_out,
    .byte_lines_oe);
`default_nettype wire

// ---- verification/asr_ctrl_test.sv ----
// self-checking bench for the static memory access controller
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_test
    import asr_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [ASR_ADDR_W-1:0] req_address = '0;
    logic [ASR_DATA_W-1:0] req_wdata = '0;
    logic req_ready, rsp_valid, sel_n, sel_h, gate_n, strobe_n, oe;
    logic [ASR_ADDR_W-1:0] addr;
    logic [ASR_DATA_W-1:0] rdata, lines_out, lines;
    int error_cnt = 0;
    int num_checks = 0;
    asr_ctrl u_dut (.ref_clk, .rst, .req_valid, .req_write, .req_address, .req_wdata,
        .req_ready, .rsp_valid, .rsp_rdata(rdata), .word_address(addr),
        .select_low_active_n(sel_n), .select_high_active(sel_h), .gate_n, .strobe_n,
        .byte_lines_in(lines), .byte_lines_out(lines_out), .byte_lines_oe(oe));
    asr_mem_model u_mem (.word_address(addr), .select_low_active_n(sel_n),
        .select_high_active(sel_h), .gate_n, .strobe_n, .host_lines(lines_out),
        .host_oe(oe), .byte_lines(lines));
    initial
        forever #10 ref_clk = ~ref_clk;
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // one request, waits for take and answer; n counts cycles from take
    task automatic access(input logic w, input logic [ASR_ADDR_W-1:0] a,
        input logic [ASR_DATA_W-1:0] d);
        int n;
        n = 0;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = w;
        req_address = a;
        req_wdata = d;
        // ready seen at a falling edge means the next rising edge takes the request
        while (req_ready !== 1'b1 && n < 50)
        begin
            n++;
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 1;
        while (rsp_valid !== 1'b1 && n < 50)
        begin
            n++;
            @(negedge ref_clk);
        end
        check("latency", n, w ? 4 : 7);
    endtask : access
    task automatic t_table;
        logic [16:0] a [4] = '{17'h1FFFF, 17'h00000, 17'h0AAAA, 17'h15555};
        logic [7:0] d [4] = '{8'h3C, 8'hC3, 8'h00, 8'hFF};
        foreach (a[i])
            access(1'b1, a[i], d[i]);
        foreach (a[i])
        begin
            access(1'b0, a[i], 8'h00);
            check("read back", rdata, d[i]);
        end
    endtask : t_table
    task automatic t_untouched;
        access(1'b0, 17'h12345, 8'h00);
        check("untouched", rdata, 8'h45 ^ 8'hA5);
    endtask : t_untouched
    task automatic t_reset_again;
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("idle pins", {req_ready, rsp_valid, sel_n, sel_h, gate_n, strobe_n, oe}, 7'h16);
        rst = 1'b0;
        access(1'b0, 17'h1FFFF, 8'h00);
        check("kept", rdata, 8'h3C);
    endtask : t_reset_again
    initial
    begin
        #20000;
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_table();
        t_untouched();
        t_reset_again();
        wrap_up();
    end
endmodule : asr_ctrl_test
`default_nettype wire
